// *** logic/mcd_pkg.sv ***
// Package for the command decoder: operations, codes, formats and state types.
package mcd_pkg;

    // Holding register width and data formats
    localparam int REG_W = 16;

    // Request operations from the slave protocol engine
    localparam logic [2:0] OP_CMD_WR  = 3'h0; // Holding write to command register
    localparam logic [2:0] OP_CMD_RD  = 3'h1; // Holding read of command register
    localparam logic [2:0] OP_COIL_WR = 3'h2; // Coil write, function 05 or 15
    localparam logic [2:0] OP_COIL_RD = 3'h3; // Coil read, function 01
    localparam logic [2:0] OP_ERR_RD  = 3'h4; // Read of command error register

    // Command codes
    localparam logic [15:0] CMD_NONE   = 16'h0000;
    localparam logic [15:0] CMD_START  = 16'h0001;
    localparam logic [15:0] CMD_REM_ON = 16'h0002;
    localparam logic [15:0] CMD_REM_OF = 16'h0003;
    localparam logic [15:0] CMD_FB_STP = 16'h000a; // Zero codes are multiples of ten
    localparam logic [15:0] CMD_FB_MAX = 16'h0050; // Highest zero code, block eight

    // Exception codes
    localparam logic [7:0] EXC_NONE  = 8'h00;
    localparam logic [7:0] EXC_FUNC  = 8'h01; // Illegal function
    localparam logic [7:0] EXC_VALUE = 8'h03; // Illegal data value
    localparam logic [7:0] EXC_NAK   = 8'h07; // Received but cannot perform

    // Command error register values
    localparam logic [15:0] ERR_NONE    = 16'h0000;
    localparam logic [15:0] ERR_UNKNOWN = 16'h0001; // Code has no action
    localparam logic [15:0] ERR_STATE   = 16'h0002; // Wrong device state

    // Coil value bit inside request data
    localparam int COIL_ON_BIT = 0;

    // Operation state, one-hot
    typedef enum logic [1:0]
    {
        RUN_WAIT = 2'b01,
        RUN_GO   = 2'b10
    } mcd_run_e;

    // Scaled integer triple: high word, low word, decimals
    function automatic logic [3*REG_W-1:0] mcd_scaled_pack(input logic signed [31:0] val,
                                                            input logic [REG_W-1:0] decs);
        mcd_scaled_pack = {val[31:16], val[15:0], decs}; // RL17 RL18
    endfunction

endpackage

// *** logic/mcd_top.sv ***
// Command decoder behind the slave register map: command register and coils.
//
// Operation
// RL1: Command register reads always return zero
// RL2: Nonzero code triggers its one action
// RL3: Impossible action answers with an exception
// RL4: Error register explains exceptions 03 and 07
// RL5: Code 1 starts, only while awaiting start
// RL6: Code 2 enters remote, keys disabled
// RL7: Code 3 leaves remote, keys enabled
// RL8: Codes 10..80 zero function block code/10
// RL9: Master writes coils with function 05/15
// RL10: Coil N executes command N
// RL11: Coil acts only when written ON
// RL12: Coil OFF acknowledged, no action
// RL13: Coils are write-only, never read back
// RL14: Multi-coil write uses lowest coil only
// RL15: Data carried in 16-bit holding registers
// RL16: Unsigned integer uses one register
// RL17: Scaled integer: 32-bit value plus decimals
// RL18: First register upper half, second lower
// RL19: Float access even count, even address
// RL20: Code 03 bad value, 07 cannot perform
// RL21: Unknown code rejected, no state change
`timescale 1ns/1ns

module mcd_top
#(
    parameter int FB_COUNT = 8 // Function blocks served
)
(
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Request from slave protocol engine
    input  wire logic                        req_valid,
    input  wire logic [2:0]                  req_op,
    input  wire logic [mcd_pkg::REG_W-1:0]   req_addr,
    input  wire logic [mcd_pkg::REG_W-1:0]   req_data,
    // Answer to slave protocol engine
    output logic                             rsp_valid,
    output logic                             rsp_exc,
    output logic [7:0]                       rsp_code,
    output logic [mcd_pkg::REG_W-1:0]        rsp_data,
    // Device actions and status
    output logic                             op_running,
    output logic                             start_pulse,
    output logic                             remote_mode,
    output logic                             keys_enable,
    output logic [FB_COUNT-1:0]              fb_zero
);
    import mcd_pkg::*;

    // Refuse sizes the code table cannot reach
    if (FB_COUNT < 1 || FB_COUNT > 8)
    begin : g_bad_count
        $error("FB_COUNT must be 1 to 8");
    end

    // All state of the block
    typedef struct packed
    {
        mcd_run_e             run;    // Awaiting start or running
        logic                 remote; // Remote operation, keys off
        logic                 start;  // Start action pulse
        logic [FB_COUNT-1:0]  fbz;    // Zero action pulses
        logic                 rv;     // Answer valid
        logic                 rexc;   // Answer is exception
        logic [7:0]           rcode;  // Exception code
        logic [REG_W-1:0]     rdata;  // Read data
        logic [REG_W-1:0]     err;    // Command error register
    } mcd_state_s;

    mcd_state_s          st_q;     // Registered state
    mcd_state_s          st_d;     // Next state
    logic [REG_W-1:0]    code_v;   // Command code of this request
    logic                exec_v;   // Request asks for an action
    logic [REG_W-1:0]    fbi_v;    // Zero target, block index

    // Code comes from data for the register, from the coil number for coils
    always_comb
    begin
        code_v = (req_op == OP_COIL_WR) ? req_addr : req_data; // RL10 RL14
        exec_v = req_valid && ((req_op == OP_CMD_WR) ||
                 ((req_op == OP_COIL_WR) && req_data[COIL_ON_BIT])); // RL11 RL12
        fbi_v  = code_v / CMD_FB_STP;
    end

    // Next state: decode, act, answer
    always_comb
    begin
        st_d       = st_q;
        // Action pulses last one cycle
        st_d.start = 1'b0;
        st_d.fbz   = '0;
        st_d.rv    = 1'b0;
        if (req_valid)
        begin
            // Every request gets exactly one answer next cycle
            st_d.rv    = 1'b1;
            st_d.rexc  = 1'b0;
            st_d.rcode = EXC_NONE;
            st_d.rdata = '0;
            case (req_op)
                OP_CMD_WR, OP_COIL_WR:
                begin
                    // Written value itself is never kept
                end
                OP_CMD_RD:
                begin
                    st_d.rdata = '0; // RL1
                end
                OP_COIL_RD:
                begin
                    // Coil state hidden, reads as OFF
                    st_d.rdata = '0; // RL13
                end
                OP_ERR_RD:
                begin
                    st_d.rdata = st_q.err; // RL4 RL16
                end
                default:
                begin
                    // Unknown operation is an illegal function
                    st_d.rexc  = 1'b1;
                    st_d.rcode = EXC_FUNC;
                end
            endcase
        end
        if (exec_v)
        begin
            // One action per accepted code
            st_d.err = ERR_NONE; // RL2
            case (code_v)
                CMD_NONE:
                begin
                    // Code zero does nothing beyond clearing the error register
                end
                CMD_START:
                begin
                    if (st_q.run == RUN_WAIT)
                    begin
                        st_d.run   = RUN_GO; // RL5
                        st_d.start = 1'b1;
                    end
                    else
                    begin
                        // Already running: cannot perform
                        st_d.rexc  = 1'b1; // RL3
                        st_d.rcode = EXC_NAK; // RL20
                        st_d.err   = ERR_STATE; // RL4
                    end
                end
                CMD_REM_ON:
                begin
                    st_d.remote = 1'b1; // RL6
                end
                CMD_REM_OF:
                begin
                    st_d.remote = 1'b0; // RL7
                end
                default:
                begin
                    // Multiples of ten from 10 to 80, up to FB_COUNT blocks, select a block; anything else is refused
                    if (code_v >= CMD_FB_STP && code_v <= CMD_FB_MAX &&
                        (code_v % CMD_FB_STP) == '0 && fbi_v <= REG_W'(FB_COUNT))
                    begin
                        st_d.fbz[3'(fbi_v - 16'h0001)] = 1'b1; // RL8
                    end
                    else
                    begin
                        // No device state touched on unknown code; answer and error register are set
                        st_d.rexc  = 1'b1; // RL21
                        st_d.rcode = EXC_VALUE; // RL20
                        st_d.err   = ERR_UNKNOWN; // RL4
                    end
                end
            endcase
        end
    end

    // State register; device comes up awaiting start, keys enabled
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '{run: RUN_WAIT, remote: 1'b0, start: 1'b0, fbz: '0, rv: 1'b0,
                      rexc: 1'b0, rcode: 8'h00, rdata: 16'h0000, err: 16'h0000};
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign rsp_valid   = st_q.rv;
    assign rsp_exc     = st_q.rexc;
    assign rsp_code    = st_q.rcode;
    assign rsp_data    = st_q.rdata; // RL15
    assign op_running  = (st_q.run == RUN_GO);
    assign start_pulse = st_q.start;
    assign remote_mode = st_q.remote;
    // Keys follow remote mode inversely
    assign keys_enable = ~st_q.remote; // RL6 RL7
    assign fb_zero     = st_q.fbz;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Read of command register answers zero, no exception
    property p_cmd_read_zero; // RL1
        req_valid && req_op == OP_CMD_RD |=> rsp_valid && !rsp_exc && rsp_data == 16'h0000;
    endproperty
    a_cmd_read_zero: assert property (p_cmd_read_zero) else $error("command read not zero"); // RL1

    // Code zero triggers nothing
    property p_code_zero; // RL2
        req_valid && req_op == OP_CMD_WR && req_data == CMD_NONE
        |=> !rsp_exc && !start_pulse && fb_zero == '0 && $stable(remote_mode) && $stable(op_running);
    endproperty
    a_code_zero: assert property (p_code_zero) else $error("code zero acted"); // RL2

    // Start pulse only on the step from waiting to running
    property p_start_edge; // RL5
        start_pulse |-> op_running && !$past(op_running) ##1 !start_pulse;
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("start pulse wrong"); // RL5

    // Start while running refused with 07 and error detail
    property p_start_refused; // RL3
        req_valid && req_op == OP_CMD_WR && req_data == CMD_START && op_running
        |=> rsp_exc && rsp_code == EXC_NAK && !start_pulse && st_q.err == ERR_STATE;
    endproperty
    a_start_refused: assert property (p_start_refused) else $error("start not refused"); // RL3 RL4 RL20

    // Remote on disables keys, remote off enables them
    property p_remote_on; // RL6
        req_valid && req_op == OP_CMD_WR && req_data == CMD_REM_ON |=> remote_mode && !keys_enable;
    endproperty
    a_remote_on: assert property (p_remote_on) else $error("remote not entered"); // RL6

    property p_remote_off; // RL7
        req_valid && req_op == OP_CMD_WR && req_data == CMD_REM_OF |=> !remote_mode && keys_enable;
    endproperty
    a_remote_off: assert property (p_remote_off) else $error("remote not left"); // RL7

    // Code 30 zeroes block three only, for one cycle
    property p_fb_three; // RL8
        req_valid && req_op == OP_CMD_WR && req_data == 16'h001e
        |=> fb_zero == FB_COUNT'(8'h04) && !rsp_exc ##1 (!fb_zero[2] || $past(req_valid));
    endproperty
    a_fb_three: assert property (p_fb_three) else $error("block zero wrong"); // RL8

    // Coil OFF acknowledged without action
    property p_coil_off; // RL12
        req_valid && req_op == OP_COIL_WR && !req_data[COIL_ON_BIT]
        |=> rsp_valid && !rsp_exc && !start_pulse && fb_zero == '0 && $stable(remote_mode);
    endproperty
    a_coil_off: assert property (p_coil_off) else $error("coil off acted"); // RL12

    // Coil one ON while waiting starts the device
    property p_coil_start; // RL11
        req_valid && req_op == OP_COIL_WR && req_data[COIL_ON_BIT] && req_addr == CMD_START && !op_running
        |=> start_pulse && op_running;
    endproperty
    a_coil_start: assert property (p_coil_start) else $error("coil start missed"); // RL10 RL11 RL14

    // Coil reads never show coil state
    property p_coil_hidden; // RL13
        req_valid && req_op == OP_COIL_RD |=> rsp_data == 16'h0000;
    endproperty
    a_coil_hidden: assert property (p_coil_hidden) else $error("coil state exposed"); // RL13

    // Unknown code refused with 03 and no state change
    property p_unknown; // RL21
        req_valid && req_op == OP_CMD_WR && req_data == 16'h0004
        |=> rsp_exc && rsp_code == EXC_VALUE && $stable(op_running) && $stable(remote_mode) && fb_zero == '0;
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown code accepted"); // RL21 RL20

endmodule

// *** dv/mcd_master.sv ***
// Master-side stand-in: issues one-word requests and collects the answers
`timescale 1ns/1ns

module mcd_master
(
    // Clock
    input  wire logic        clk,
    // Request side
    output logic             req_valid,
    output logic [2:0]       req_op,
    output logic [15:0]      req_addr,
    output logic [15:0]      req_data,
    // Answer side
    input  wire logic        rsp_valid,
    input  wire logic        rsp_exc,
    input  wire logic [7:0]  rsp_code,
    input  wire logic [15:0] rsp_data
);
    // Idle bus at time zero
    initial
    begin
        req_valid = 1'b0;
        req_op    = 3'h0;
        req_addr  = 16'h0000;
        req_data  = 16'h0000;
    end

    // One request; coil writes carry only the lowest coil of the request
    // Single words only, so no float pair is ever split or started odd
    task automatic xfer(input logic [2:0] op, input logic [15:0] addr, input logic [15:0] data,
                        output logic vld, output logic exc, output logic [7:0] code,
                        output logic [15:0] rd);
        @(negedge clk);
        req_valid = 1'b1;
        req_op    = op;
        req_addr  = addr;
        req_data  = data;
        // Answer stands only the cycle after the taking edge; catch it mid-cycle
        @(negedge clk);
        vld  = rsp_valid;
        exc  = rsp_exc;
        code = rsp_code;
        rd   = rsp_data;
        // Released words flip so stale values never pass for fresh ones
        req_valid = 1'b0;
        req_addr  = ~addr;
        req_data  = ~data;
    endtask
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the command decoder
`timescale 1ns/1ns

module tb_top;
    import mcd_pkg::*;

    logic        clk;         // 20 MHz clock
    logic        rst_n;       // Async reset, active low
    logic        req_valid;   // Request strobe
    logic [2:0]  req_op;      // Request operation
    logic [15:0] req_addr;    // Coil number
    logic [15:0] req_data;    // Code or coil value
    logic        rsp_valid;   // Answer strobe
    logic        rsp_exc;     // Exception flag
    logic [7:0]  rsp_code;    // Exception code
    logic [15:0] rsp_data;    // Read data
    logic        op_running;  // Running level
    logic        start_pulse; // Start action
    logic        remote_mode; // Remote level
    logic        keys_enable; // Front keys level
    logic [7:0]  fb_zero;     // Block zero pulses
    logic        vld;         // Captured answer strobe
    logic        exc;         // Captured exception
    logic [7:0]  code;        // Captured code
    logic [15:0] rd;          // Captured read data
    int          num_errors;  // Mismatches
    int          checks_done; // Comparisons

    // Design and master stand-in
    mcd_top mcd_top_inst (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_data(req_data), .rsp_valid(rsp_valid), .rsp_exc(rsp_exc),
        .rsp_code(rsp_code), .rsp_data(rsp_data), .op_running(op_running), .start_pulse(start_pulse),
        .remote_mode(remote_mode), .keys_enable(keys_enable), .fb_zero(fb_zero));
    mcd_master mcd_master_inst (.clk(clk), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
        .req_data(req_data), .rsp_valid(rsp_valid), .rsp_exc(rsp_exc), .rsp_code(rsp_code),
        .rsp_data(rsp_data));

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // One comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One request with its expected answer kind
    task automatic send(input logic [2:0] op, input logic [15:0] a, input logic [15:0] d,
                        input logic e_exc, input logic [7:0] e_code);
        mcd_master_inst.xfer(op, a, d, vld, exc, code, rd);
        chk(16'(vld), 16'h0001);
        chk(16'(exc), 16'(e_exc));
        chk(16'(code), 16'(e_code));
    endtask

    // Error register read
    task automatic err_is(input logic [15:0] e);
        send(OP_ERR_RD, 16'h0000, 16'h0000, 1'b0, EXC_NONE);
        chk(rd, e);
    endtask

    // Counts and verdict
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog at 3000 cycles, well beyond the 120 or so cycles the tests need
    initial
    begin
        #(50 * 3000);
        num_errors++;
        complete_run();
    end

    // Test sequence
    initial
    begin
        logic [15:0] bad [6];
        logic [47:0] trip;
        num_errors  = 0;
        checks_done = 0;
        rst_n = 1'b0;
        bad = '{16'h0004, 16'h0005, 16'h0009, 16'h000b, 16'h005a, 16'hffff};
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        chk({13'h0, op_running, remote_mode, keys_enable}, 16'h0001);
        // Code zero: plain answer, nothing fires
        send(OP_CMD_WR, 16'h0000, CMD_NONE, 1'b0, EXC_NONE);
        chk({7'h0, start_pulse, fb_zero}, 16'h0000);
        $display("test zero code done");
        // Unknown codes refused, state untouched
        foreach (bad[i])
        begin
            send(OP_CMD_WR, 16'h0000, bad[i], 1'b1, EXC_VALUE);
            chk({6'h0, op_running, start_pulse, fb_zero}, 16'h0000);
            err_is(ERR_UNKNOWN);
        end
        $display("test unknown codes done");
        // Start once, then refused while running
        send(OP_CMD_WR, 16'h0000, CMD_START, 1'b0, EXC_NONE);
        chk({14'h0, start_pulse, op_running}, 16'h0003);
        err_is(ERR_NONE);
        send(OP_CMD_WR, 16'h0000, CMD_START, 1'b1, EXC_NAK);
        chk(16'(start_pulse), 16'h0000);
        err_is(ERR_STATE);
        $display("test start done");
        // Remote by register, leave by coil, coil off does nothing
        send(OP_CMD_WR, 16'h0000, CMD_REM_ON, 1'b0, EXC_NONE);
        chk({14'h0, remote_mode, keys_enable}, 16'h0002);
        send(OP_CMD_RD, 16'h0000, 16'h0000, 1'b0, EXC_NONE);
        chk(rd, 16'h0000);
        send(OP_COIL_WR, 16'h0003, 16'h0001, 1'b0, EXC_NONE);
        chk({14'h0, remote_mode, keys_enable}, 16'h0001);
        send(OP_COIL_WR, 16'h0002, 16'h0000, 1'b0, EXC_NONE);
        chk({14'h0, remote_mode, keys_enable}, 16'h0001);
        $display("test remote done");
        // Every block zero code, by register and by coil
        for (int k = 1; k <= 8; k++)
        begin
            send(OP_CMD_WR, 16'h0000, 16'(k * 10), 1'b0, EXC_NONE);
            chk(16'(fb_zero), 16'(1 << (k - 1)));
            send(OP_COIL_WR, 16'(k * 10), 16'h0001, 1'b0, EXC_NONE);
            chk(16'(fb_zero), 16'(1 << (k - 1)));
            send(OP_COIL_WR, 16'(k * 10), 16'h0000, 1'b0, EXC_NONE);
            chk(16'(fb_zero), 16'h0000);
        end
        $display("test block zero done");
        // Coils read back as off, bad operation refused
        send(OP_COIL_RD, 16'h000a, 16'h0000, 1'b0, EXC_NONE);
        chk(rd, 16'h0000);
        send(3'h5, 16'h0000, 16'h0000, 1'b1, EXC_FUNC);
        // Scaled triple: 12345678 with three decimals
        trip = mcd_scaled_pack(32'sd12345678, 16'h0003);
        chk(trip[47:32], 16'h00bc);
        chk(trip[31:16], 16'h614e);
        chk(trip[15:0], 16'h0003);
        $display("test misc done");
        // Mid-run reset drops remote mode, then start by coil
        send(OP_CMD_WR, 16'h0000, CMD_REM_ON, 1'b0, EXC_NONE);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk({13'h0, op_running, remote_mode, keys_enable}, 16'h0001);
        send(OP_COIL_WR, CMD_START, 16'h0001, 1'b0, EXC_NONE);
        chk({14'h0, start_pulse, op_running}, 16'h0003);
        $display("test reset and coil start done");
        complete_run();
    end
endmodule
